// ===== core/drive_pkg.sv
// shared constants, types and object map for the drive power state and velocity logic
package drive_pkg;

  // -------------------------------------------------------------
  // object dictionary indices and sub-indices
  // -------------------------------------------------------------
  localparam logic [15:0] IDX_COMMAND = 16'h6040;
  localparam logic [15:0] IDX_REPORT = 16'h6041;
  localparam logic [15:0] IDX_SETPOINT = 16'h6042;
  localparam logic [15:0] IDX_DEMAND = 16'h6043;
  localparam logic [15:0] IDX_MEASURED = 16'h6044;
  localparam logic [15:0] IDX_BOUNDS = 16'h6046;
  localparam logic [15:0] IDX_ACCEL = 16'h6048;
  localparam logic [15:0] IDX_DECEL = 16'h6049;
  localparam logic [7:0] SUB_VALUE = 8'h00;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] SUB_SECOND = 8'h02;
  localparam logic [31:0] SUB_HIGHEST = 32'h00000002;

  // -------------------------------------------------------------
  // command word field positions
  // -------------------------------------------------------------
  localparam int CMD_SWITCH_ON = 0;
  localparam int CMD_POWER_STAGE = 1;
  localparam int CMD_RAPID_STOP_N = 2;
  localparam int CMD_RUN = 3;
  localparam int CMD_RAMP_ENABLE = 4;
  localparam int CMD_RAMP_UNLOCK = 5;
  localparam int CMD_RAMP_REFERENCE = 6;
  localparam int CMD_ERROR_CLEAR = 7;
  localparam int CMD_HALT = 8;
  localparam int CMD_MODE_HIGH = 9;

  // -------------------------------------------------------------
  // status word field positions
  // -------------------------------------------------------------
  localparam int ST_FAULT = 3;
  localparam int ST_SUPPLY = 4;
  localparam int ST_WARNING = 7;
  localparam int ST_SYNC = 8;
  localparam int ST_EXTERNAL = 9;
  localparam int ST_GOAL = 10;
  localparam int ST_LIMIT = 11;
  localparam int ST_LOOP = 15;

  // -------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------
  localparam logic [15:0] COMMAND_RESET = 16'h0000;
  localparam logic [15:0] REPORT_RESET = 16'h0000;
  localparam logic [15:0] SETPOINT_RESET = 16'h00C8;
  localparam logic [15:0] SPEED_RESET = 16'h0000;
  localparam logic [31:0] FLOOR_RESET = 32'h00000000;
  localparam logic [31:0] CEILING_RESET = 32'h00007530;
  localparam logic [31:0] SPEED_STEP_RESET = 32'h000001F4;
  localparam logic [15:0] TIME_STEP_RESET = 16'h0001;

  // -------------------------------------------------------------
  // timing: one ramp time unit is one millisecond
  // -------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TIME_UNIT_NS = 1000000;
  localparam int TIME_UNIT_CYCLES = TIME_UNIT_NS / CLK_PERIOD_NS;

  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    PS_NOT_READY = 3'b000,
    PS_LOCKOUT = 3'b001,
    PS_STANDBY = 3'b011,
    PS_SWITCHED_ON = 3'b010,
    PS_RUNNING = 3'b110,
    PS_RAPID_STOP = 3'b111,
    PS_FAULT_REACT = 3'b101,
    PS_FAULT = 3'b100
  } power_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
  } od_req_s;

  typedef struct packed {
    logic ack;
    logic abort;
    logic [31:0] rdata;
  } od_rsp_s;

  typedef struct packed {
    logic [31:0] speed_step;
    logic [15:0] time_step;
  } ramp_s;

endpackage

// ===== core/drive_power_velocity.sv
// power state machine, status word and velocity-mode ramp of the motor drive

// Notes on behaviour
// - command bit 0 set requests the move into switched on.
// - command bit 1 set requests power stage supply enable.
// - command bit 2 low forces rapid stop from running.
// - command bit 3 set requests the move into running.
// - command bit 7 clears a fault only once the fault cause has gone.
// - command bit 8 set halts motion in velocity mode.
// - command bits 4 to 6 take velocity-mode meanings; bit 9 only appears on mode_specific_bits.
// - status word is read-only, sixteen bits, resets to zero, tracks state.
// - status bits 6,5,3,2,1,0 encode the eight power states.
// - status bit 0 is one while standing ready to switch on.
// - status bit 2 is one while running.
// - status bit 6 is one while locked out.
// - status bit 8 shows fieldbus synchronisation.
// - status bit 9 reads one from the first clock edge after reset.
// - status bit 15 is one only running with closed loop active.
// - target speed is signed sixteen-bit read/write, resets to 0x00C8.
// - measured speed is read-only signed sixteen-bit, resets to zero.
// - target below floor uses floor and sets status bit 11.
// - target above ceiling uses ceiling and sets status bit 11.
// - acceleration is speed step per time step, resets 0x1F4 and 0x1.
// - deceleration has its own speed step and time step pair.
// - command word is sixteen-bit read/write, resets to zero.
module drive_power_velocity #(
  parameter int TICK_CYCLES = drive_pkg::TIME_UNIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire drive_pkg::od_req_s od_req,
  output drive_pkg::od_rsp_s od_rsp,
  input wire logic fault_in,
  input wire logic warning_in,
  input wire logic sync_in,
  input wire logic closed_loop_in,
  input wire logic [15:0] speed_meas_in,
  output logic [15:0] speed_demand,
  output logic power_stage_enable,
  output logic [3:0] mode_specific_bits
);

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  logic [15:0] command_reg;
  logic [15:0] report_reg;
  logic [15:0] setpoint_reg;
  logic [15:0] demand_reg;
  logic [15:0] measured_reg;
  logic [31:0] floor_reg;
  logic [31:0] ceiling_reg;
  drive_pkg::ramp_s accel_reg;
  drive_pkg::ramp_s decel_reg;
  drive_pkg::power_state_e state_reg;
  drive_pkg::power_state_e state_next;
  drive_pkg::od_rsp_s rsp_reg;
  logic clear_seen_reg;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] clean_reg;
  logic [15:0] tick_cnt_reg;
  logic [15:0] unit_cnt_reg;

  // cleaned pin levels
  logic fault_ok;
  logic warn_ok;
  logic sync_ok;
  logic loop_ok;
  assign fault_ok = clean_reg[0];
  assign warn_ok = clean_reg[1];
  assign sync_ok = clean_reg[2];
  assign loop_ok = clean_reg[3];

  // -------------------------------------------------------------
  // pin input conditioning
  // -------------------------------------------------------------
  // three stages; a level counts only once stages two and three agree
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
      clean_reg <= 4'h0;
    end
    else
    begin
      sync1_reg <= {closed_loop_in, sync_in, warning_in, fault_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      clean_reg <= (sync3_reg & ~(sync2_reg ^ sync3_reg)) | (clean_reg & (sync2_reg ^ sync3_reg));
    end
  end

  // -------------------------------------------------------------
  // object access decode
  // -------------------------------------------------------------
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_data;
  logic wr_cmd;
  logic wr_set;
  logic wr_floor;
  logic wr_ceil;
  logic wr_acc_s;
  logic wr_acc_t;
  logic wr_dec_s;
  logic wr_dec_t;

  // index first, then sub-index; anything else aborts
  always_comb
  begin
    wr_cmd = 1'b0;
    wr_set = 1'b0;
    wr_floor = 1'b0;
    wr_ceil = 1'b0;
    wr_acc_s = 1'b0;
    wr_acc_t = 1'b0;
    wr_dec_s = 1'b0;
    wr_dec_t = 1'b0;
    rd_hit = 1'b1;
    wr_hit = 1'b1;
    rd_data = 32'h00000000;
    if (od_req.index == drive_pkg::IDX_COMMAND && od_req.sub == drive_pkg::SUB_VALUE)
    begin
      rd_data = {16'h0000, command_reg};
      wr_cmd = 1'b1;
    end
    else if (od_req.index == drive_pkg::IDX_REPORT && od_req.sub == drive_pkg::SUB_VALUE)
    begin
      rd_data = {16'h0000, report_reg};
      wr_hit = 1'b0; // read only
    end
    else if (od_req.index == drive_pkg::IDX_SETPOINT && od_req.sub == drive_pkg::SUB_VALUE)
    begin
      rd_data = {{16{setpoint_reg[15]}}, setpoint_reg};
      wr_set = 1'b1;
    end
    else if (od_req.index == drive_pkg::IDX_DEMAND && od_req.sub == drive_pkg::SUB_VALUE)
    begin
      rd_data = {{16{demand_reg[15]}}, demand_reg};
      wr_hit = 1'b0;
    end
    else if (od_req.index == drive_pkg::IDX_MEASURED && od_req.sub == drive_pkg::SUB_VALUE)
    begin
      rd_data = {{16{measured_reg[15]}}, measured_reg};
      wr_hit = 1'b0;
    end
    else if ((od_req.index == drive_pkg::IDX_BOUNDS || od_req.index == drive_pkg::IDX_ACCEL
              || od_req.index == drive_pkg::IDX_DECEL) && od_req.sub == drive_pkg::SUB_VALUE)
    begin
      rd_data = drive_pkg::SUB_HIGHEST;
      wr_hit = 1'b0;
    end
    else if (od_req.index == drive_pkg::IDX_BOUNDS && od_req.sub == drive_pkg::SUB_FIRST)
    begin
      rd_data = floor_reg;
      wr_floor = 1'b1;
    end
    else if (od_req.index == drive_pkg::IDX_BOUNDS && od_req.sub == drive_pkg::SUB_SECOND)
    begin
      rd_data = ceiling_reg;
      wr_ceil = 1'b1;
    end
    else if (od_req.index == drive_pkg::IDX_ACCEL && od_req.sub == drive_pkg::SUB_FIRST)
    begin
      rd_data = accel_reg.speed_step;
      wr_acc_s = 1'b1;
    end
    else if (od_req.index == drive_pkg::IDX_ACCEL && od_req.sub == drive_pkg::SUB_SECOND)
    begin
      rd_data = {16'h0000, accel_reg.time_step};
      wr_acc_t = 1'b1;
    end
    else if (od_req.index == drive_pkg::IDX_DECEL && od_req.sub == drive_pkg::SUB_FIRST)
    begin
      rd_data = decel_reg.speed_step;
      wr_dec_s = 1'b1;
    end
    else if (od_req.index == drive_pkg::IDX_DECEL && od_req.sub == drive_pkg::SUB_SECOND)
    begin
      rd_data = {16'h0000, decel_reg.time_step};
      wr_dec_t = 1'b1;
    end
    else
    begin
      rd_hit = 1'b0;
      wr_hit = 1'b0;
    end
  end

  logic do_wr;
  assign do_wr = od_req.valid && od_req.write && wr_hit;

  // writable objects; narrow objects take the low bits of the write data
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      command_reg <= drive_pkg::COMMAND_RESET;
      setpoint_reg <= drive_pkg::SETPOINT_RESET;
      floor_reg <= drive_pkg::FLOOR_RESET;
      ceiling_reg <= drive_pkg::CEILING_RESET;
      accel_reg <= '{drive_pkg::SPEED_STEP_RESET, drive_pkg::TIME_STEP_RESET};
      decel_reg <= '{drive_pkg::SPEED_STEP_RESET, drive_pkg::TIME_STEP_RESET};
    end
    else if (do_wr)
    begin
      if (wr_cmd) command_reg <= od_req.wdata[15:0];
      if (wr_set) setpoint_reg <= od_req.wdata[15:0];
      if (wr_floor) floor_reg <= od_req.wdata;
      if (wr_ceil) ceiling_reg <= od_req.wdata;
      if (wr_acc_s) accel_reg.speed_step <= od_req.wdata;
      if (wr_acc_t) accel_reg.time_step <= od_req.wdata[15:0];
      if (wr_dec_s) decel_reg.speed_step <= od_req.wdata;
      if (wr_dec_t) decel_reg.time_step <= od_req.wdata[15:0];
    end
  end

  // answer one cycle after the request; read-only or unknown write aborts
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rsp_reg <= '0;
    else
    begin
      rsp_reg.ack <= od_req.valid;
      rsp_reg.abort <= od_req.valid && (od_req.write ? !wr_hit : !rd_hit);
      rsp_reg.rdata <= (od_req.valid && !od_req.write && rd_hit) ? rd_data : 32'h00000000;
    end
  end
  assign od_rsp = rsp_reg;

  // -------------------------------------------------------------
  // power state machine
  // -------------------------------------------------------------
  logic c_on;
  logic c_volt;
  logic c_qs_n;
  logic c_run;
  logic clear_rise;
  assign c_on = command_reg[drive_pkg::CMD_SWITCH_ON];
  assign c_volt = command_reg[drive_pkg::CMD_POWER_STAGE];
  assign c_qs_n = command_reg[drive_pkg::CMD_RAPID_STOP_N];
  assign c_run = command_reg[drive_pkg::CMD_RUN];
  assign clear_rise = command_reg[drive_pkg::CMD_ERROR_CLEAR] && !clear_seen_reg;

  // error clear acts on its rising edge so a held bit does not loop a fault
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      clear_seen_reg <= 1'b0;
    else
      clear_seen_reg <= command_reg[drive_pkg::CMD_ERROR_CLEAR];
  end

  logic demand_zero;
  assign demand_zero = (demand_reg == 16'h0000);

  // a pending fault outranks every command
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      drive_pkg::PS_NOT_READY: state_next = drive_pkg::PS_LOCKOUT;
      drive_pkg::PS_LOCKOUT:
        if (c_volt && c_qs_n && !c_on) state_next = drive_pkg::PS_STANDBY;
      drive_pkg::PS_STANDBY:
        if (!c_volt || !c_qs_n) state_next = drive_pkg::PS_LOCKOUT;
        else if (c_on) state_next = drive_pkg::PS_SWITCHED_ON;
      drive_pkg::PS_SWITCHED_ON:
        if (!c_volt || !c_qs_n) state_next = drive_pkg::PS_LOCKOUT;
        else if (!c_on) state_next = drive_pkg::PS_STANDBY;
        else if (c_run) state_next = drive_pkg::PS_RUNNING;
      drive_pkg::PS_RUNNING:
        if (!c_volt) state_next = drive_pkg::PS_LOCKOUT;
        else if (!c_qs_n) state_next = drive_pkg::PS_RAPID_STOP;
        else if (!c_on) state_next = drive_pkg::PS_STANDBY;
        else if (!c_run) state_next = drive_pkg::PS_SWITCHED_ON;
      drive_pkg::PS_RAPID_STOP:
        if (!c_volt) state_next = drive_pkg::PS_LOCKOUT;
        else if (c_qs_n && c_on && c_run) state_next = drive_pkg::PS_RUNNING;
      drive_pkg::PS_FAULT_REACT:
        if (demand_zero) state_next = drive_pkg::PS_FAULT;
      drive_pkg::PS_FAULT:
        if (clear_rise && !fault_ok) state_next = drive_pkg::PS_LOCKOUT;
      default: state_next = drive_pkg::PS_NOT_READY;
    endcase
    if (fault_ok && state_reg != drive_pkg::PS_FAULT && state_reg != drive_pkg::PS_FAULT_REACT)
      state_next = drive_pkg::PS_FAULT_REACT;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_reg <= drive_pkg::PS_NOT_READY;
    else
      state_reg <= state_next;
  end

  // -------------------------------------------------------------
  // target clamp
  // -------------------------------------------------------------
  logic [15:0] tgt_mag;
  logic [31:0] tgt_mag_w;
  logic below_floor;
  logic above_ceil;
  logic [15:0] clamp_mag;
  logic [15:0] clamped;
  assign tgt_mag = setpoint_reg[15] ? 16'(-setpoint_reg) : setpoint_reg;
  assign tgt_mag_w = {16'h0000, tgt_mag};
  assign below_floor = tgt_mag_w < floor_reg;
  assign above_ceil = tgt_mag_w > ceiling_reg;

  // bounds above the signed range saturate at a speed magnitude of 0x7FFF, sign kept from the target
  always_comb
  begin
    clamp_mag = tgt_mag;
    if (below_floor)
      clamp_mag = (floor_reg > 32'h00007FFF) ? 16'h7FFF : floor_reg[15:0];
    else if (above_ceil)
      clamp_mag = (ceiling_reg > 32'h00007FFF) ? 16'h7FFF : ceiling_reg[15:0];
  end
  assign clamped = setpoint_reg[15] ? 16'(-clamp_mag) : clamp_mag;

  // -------------------------------------------------------------
  // velocity ramp
  // -------------------------------------------------------------
  logic running;
  logic ramp_go;
  logic ramp_hold;
  logic [15:0] goal;
  logic rising;
  drive_pkg::ramp_s pair;
  logic [15:0] unit_len;
  logic tick;
  logic step_now;
  assign running = (state_reg == drive_pkg::PS_RUNNING);

  // velocity-mode bits: enable or reference low zeroes the goal, unlock low freezes the demand while running
  assign ramp_go = command_reg[drive_pkg::CMD_RAMP_ENABLE]
                   && command_reg[drive_pkg::CMD_RAMP_REFERENCE];
  assign ramp_hold = running && !command_reg[drive_pkg::CMD_RAMP_UNLOCK];
  assign goal = (running && ramp_go && !command_reg[drive_pkg::CMD_HALT]) ? clamped
                : 16'h0000;

  // magnitude grows only when goal lies beyond demand on the same side
  assign rising = demand_zero ? (goal != 16'h0000)
                  : ((goal[15] == demand_reg[15]) && ($signed(goal) > $signed(demand_reg))
                     == !demand_reg[15]);
  assign pair = rising ? accel_reg : decel_reg;
  assign unit_len = (pair.time_step == 16'h0000) ? 16'h0001 : pair.time_step;
  assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));
  assign step_now = tick && (unit_cnt_reg + 16'h0001 >= unit_len);

  // free-running time unit divider plus count of elapsed units
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_reg <= 16'h0000;
      unit_cnt_reg <= 16'h0000;
    end
    else
    begin
      tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
      if (step_now) unit_cnt_reg <= 16'h0000;
      else if (tick) unit_cnt_reg <= unit_cnt_reg + 16'h0001;
    end
  end

  logic [16:0] diff;
  logic [16:0] gap;
  logic [15:0] demand_next;
  assign diff = {goal[15], goal} - {demand_reg[15], demand_reg};
  assign gap = diff[16] ? 17'(-diff) : diff;

  // move one speed step toward the goal, never overshooting it
  always_comb
  begin
    demand_next = demand_reg;
    if ({15'h0000, gap} <= pair.speed_step)
      demand_next = goal;
    else if (diff[16])
      demand_next = 16'(demand_reg - pair.speed_step[15:0]);
    else
      demand_next = 16'(demand_reg + pair.speed_step[15:0]);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      demand_reg <= drive_pkg::SPEED_RESET;
    else if (step_now && !ramp_hold)
      demand_reg <= demand_next;
  end

  // measured speed comes from logic on this clock, so no synchroniser
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      measured_reg <= drive_pkg::SPEED_RESET;
    else
      measured_reg <= speed_meas_in;
  end

  // -------------------------------------------------------------
  // status word
  // -------------------------------------------------------------
  logic [6:0] state_bits;

  // bits 6..0 per state; bit 4 shows supply applied to the stage
  always_comb
  begin
    case (state_reg)
      drive_pkg::PS_LOCKOUT: state_bits = 7'b1000000;
      drive_pkg::PS_STANDBY: state_bits = 7'b0100001;
      drive_pkg::PS_SWITCHED_ON: state_bits = 7'b0110011;
      drive_pkg::PS_RUNNING: state_bits = 7'b0110111;
      drive_pkg::PS_RAPID_STOP: state_bits = 7'b0010111;
      drive_pkg::PS_FAULT_REACT: state_bits = 7'b0011111;
      drive_pkg::PS_FAULT: state_bits = 7'b0001000;
      default: state_bits = 7'b0000000;
    endcase
  end

  // rebuilt every cycle so it tracks the state one edge behind
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      report_reg <= drive_pkg::REPORT_RESET;
    else
    begin
      report_reg <= 16'h0000;
      report_reg[6:0] <= state_bits;
      report_reg[drive_pkg::ST_WARNING] <= warn_ok;
      report_reg[drive_pkg::ST_SYNC] <= sync_ok;
      report_reg[drive_pkg::ST_EXTERNAL] <= 1'b1;
      report_reg[drive_pkg::ST_GOAL] <= running && (demand_reg == goal);
      report_reg[drive_pkg::ST_LIMIT] <= below_floor || above_ceil;
      report_reg[drive_pkg::ST_LOOP] <= running && loop_ok;
    end
  end

  assign speed_demand = demand_reg;
  assign power_stage_enable = report_reg[drive_pkg::ST_SUPPLY];
  assign mode_specific_bits = {command_reg[drive_pkg::CMD_MODE_HIGH], command_reg[6:4]};

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_switch_on_req: assert property (
    (state_reg == drive_pkg::PS_STANDBY) && c_on && c_volt && c_qs_n && !fault_ok
    |=> state_reg == drive_pkg::PS_SWITCHED_ON)
    else $error("switch on request not taken");
  a_rapid_stop_in: assert property (
    running && c_volt && !c_qs_n && !fault_ok |=> state_reg == drive_pkg::PS_RAPID_STOP ##1
    report_reg[5] == 1'b0 && report_reg[2:0] == 3'b111)
    else $error("rapid stop not entered");
  a_fault_clear: assert property (
    (state_reg == drive_pkg::PS_FAULT) && fault_ok |=> state_reg == drive_pkg::PS_FAULT)
    else $error("fault left while cause present");
  a_ready_bits: assert property (
    state_reg == drive_pkg::PS_STANDBY |=> report_reg[0] && report_reg[6:5] == 2'b01)
    else $error("ready bits wrong");
  a_run_bit: assert property (
    $rose(running) |=> report_reg[2] && report_reg[1])
    else $error("running bit missing");
  a_lockout_bit: assert property (
    report_reg[6] |-> $past(state_reg) == drive_pkg::PS_LOCKOUT)
    else $error("lockout bit without lockout");
  a_external_one: assert property (
    state_reg != drive_pkg::PS_NOT_READY |-> report_reg[drive_pkg::ST_EXTERNAL])
    else $error("remote bit low");
  a_loop_bit: assert property (
    report_reg[drive_pkg::ST_LOOP] |-> $past(running) && $past(loop_ok))
    else $error("closed loop bit wrong");
  a_floor_limit: assert property (
    below_floor |-> clamp_mag != tgt_mag || floor_reg[15:0] == tgt_mag ##1
    report_reg[drive_pkg::ST_LIMIT])
    else $error("floor limit not flagged");
  a_limit_clears: assert property (
    !below_floor && !above_ceil |=> !report_reg[drive_pkg::ST_LIMIT])
    else $error("limit bit stuck");
  a_demand_steps: assert property (
    demand_reg != $past(demand_reg) |-> $past(step_now) && !$past(ramp_hold))
    else $error("demand moved off a step");

endmodule

// ===== dv/drive_master.sv
// fieldbus master model issuing object accesses to the drive
module drive_master (
  input wire logic clk_sys,
  output drive_pkg::od_req_s od_req,
  input wire drive_pkg::od_rsp_s od_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial od_req = '0;
  // one access: request held for the taking edge, answer taken one edge later
  // released fields show inverted values so a stale bus is never mistaken for a request
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
    input logic [31:0] wd, output drive_pkg::od_rsp_s rsp);
    od_req <= '{1'b1, wr, idx, sub, wd};
    @(posedge clk_sys);
    od_req <= '{1'b0, ~wr, ~idx, ~sub, ~wd};
    @(posedge clk_sys);
    rsp = od_rsp;
  endtask
endmodule

// ===== dv/test_drive_power_velocity.sv
// self-checking bench for the drive power state and velocity logic
module test_drive_power_velocity;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic fault_in = 1'b0;
  logic sync_in = 1'b0;
  logic loop_in = 1'b0;
  logic [15:0] meas = 16'hFF38;
  drive_pkg::od_req_s od_req;
  drive_pkg::od_rsp_s od_rsp;
  logic [15:0] demand;
  logic stage_on;
  logic [3:0] mode_bits;
  int fail_count = 0;
  int checks_done = 0;
  always #25 clk_sys = ~clk_sys;
  // short ramp tick keeps the run brief
  drive_power_velocity #(.TICK_CYCLES(8)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .od_req(od_req), .od_rsp(od_rsp), .fault_in(fault_in), .warning_in(1'b0),
    .sync_in(sync_in), .closed_loop_in(loop_in), .speed_meas_in(meas),
    .speed_demand(demand), .power_stage_enable(stage_on), .mode_specific_bits(mode_bits));
  drive_master i_master (.clk_sys(clk_sys), .od_req(od_req), .od_rsp(od_rsp));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // reads compare all bits unless a mask is passed; state-walk and fault status reads pass 0x83FF for state, warning, sync, remote and loop bits
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp,
    input logic [31:0] mask = 32'hFFFF_FFFF);
    drive_pkg::od_rsp_s r;
    i_master.access(1'b0, idx, sub, 32'h0, r);
    check("read", r.rdata & mask, exp);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
    input logic ab = 1'b0);
    drive_pkg::od_rsp_s r;
    i_master.access(1'b1, idx, sub, d, r);
    check("answer", {r.ack, r.abort}, {1'b1, ab});
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic reset_values();
    rd(16'h6041, 8'h00, 32'h0340);
    rd(16'h6040, 8'h00, 32'h0000);
    rd(16'h6042, 8'h00, 32'h00C8);
    rd(16'h6044, 8'h00, 32'hFFFF_FF38);
    rd(16'h6046, 8'h02, 32'h7530);
    rd(16'h6048, 8'h01, 32'h01F4);
    rd(16'h6048, 8'h02, 32'h0001);
    rd(16'h6049, 8'h01, 32'h01F4);
    wr(16'h6041, 8'h00, 32'hFFFF, 1'b1);
    rd(16'h6041, 8'h00, 32'h0340);
  endtask
  task automatic walk_states();
    logic [15:0] cmd[5] = '{16'h0006, 16'h0007, 16'h000F, 16'h000B, 16'h007F};
    logic [15:0] st[5] = '{16'h0321, 16'h0333, 16'h8337, 16'h0317, 16'h8337};
    for (int i = 0; i < 5; i++)
    begin
      wr(16'h6040, 8'h00, {16'h0, cmd[i]});
      rd(16'h6041, 8'h00, {16'h0, st[i]}, 32'h83FF);
    end
    check("stage", stage_on, 1'b1);
    check("mode", mode_bits, 4'b0111);
    // dropping the loop pin while running must clear the closed-loop bit
    loop_in <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(16'h6041, 8'h00, 32'h0337, 32'h83FF);
  endtask
  task automatic ramp_and_clamp();
    wr(16'h6046, 8'h02, 32'h0064);
    wr(16'h6042, 8'h00, 32'h01F4);
    repeat (40) @(posedge clk_sys);
    check("demand", demand, 16'h0064);
    rd(16'h6043, 8'h00, 32'h0064);
    rd(16'h6041, 8'h00, 32'h0800, 32'h0800);
    wr(16'h6046, 8'h01, 32'h0050);
    wr(16'h6042, 8'h00, 32'h0014);
    repeat (40) @(posedge clk_sys);
    check("floor", demand, 16'h0050);
    rd(16'h6041, 8'h00, 32'h0800, 32'h0800);
    wr(16'h6048, 8'h01, 32'h0002);
    wr(16'h6042, 8'h00, 32'h005A);
    check("slow", demand < 16'h005A, 1'b1);
    repeat (60) @(posedge clk_sys);
    check("inside", demand, 16'h005A);
    rd(16'h6041, 8'h00, 32'h0000, 32'h0800);
    wr(16'h6040, 8'h00, 32'h017F);
    repeat (40) @(posedge clk_sys);
    check("halt", demand, 16'h0000);
  endtask
  // error clear must be refused while the fault pin is still raised
  task automatic fault_recovery();
    fault_in <= 1'b1;
    repeat (40) @(posedge clk_sys);
    rd(16'h6041, 8'h00, 32'h0308, 32'h83FF);
    wr(16'h6040, 8'h00, 32'h0080);
    rd(16'h6041, 8'h00, 32'h0308, 32'h83FF);
    wr(16'h6040, 8'h00, 32'h0000);
    fault_in <= 1'b0;
    repeat (8) @(posedge clk_sys);
    wr(16'h6040, 8'h00, 32'h0080);
    rd(16'h6041, 8'h00, 32'h0340, 32'h83FF);
    // losing fieldbus sync must clear the sync bit
    sync_in <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(16'h6041, 8'h00, 32'h0240, 32'h83FF);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    sync_in <= 1'b1;
    loop_in <= 1'b1;
    repeat (8) @(posedge clk_sys);
    reset_values();
    walk_states();
    ramp_and_clamp();
    fault_recovery();
    end_of_test();
  end
  // watchdog well beyond the few hundred cycles the sequence needs
  initial
  begin
    #4000000;
    fail_count++;
    end_of_test();
  end
endmodule
